// [common/iochk_pkg.sv]
// constants, types and helpers for the i/o checking display
// assumes one 50 mhz clock and a synchronous active-high reset
//
// What this block does
// - each four status bits show as one hex digit, 0 to F, eight-weighted msb
// - segment view: digit 1 segments a..e follow forward, reverse, three general inputs
// - segment view: digit 3 segment a follows transistor output circuit closed
// - segment view: digit 4 segment a follows relay common-to-normally-open closed
// - segment view, all terminal inputs and comm commands off: segment g lights on all four digits
// - comm item uses received commands; forward, reverse, reset on digit 2 f, g, dp
// - first check item takes its states from the physical terminals
// - voltage input item shows measured input voltage in volts
// - current input item shows measured input current in milliamperes
// - meter output item shows driven meter output voltage in volts
// - up and down keys step through segment, hex input and hex output views on terminal items
// - power-on enters running mode; program key alone opens the menu
// - hex inputs: forward bit 0, reverse bit 1, general inputs bits 2..4
// - hex outputs: transistor output bit 0, relay normally-open closed bit 8

package iochk_pkg;

   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] TERMS_OFS = 4'h8;
   localparam logic [3:0] DIGITS_OFS = 4'hc;
   localparam logic [1:0] SCOPE_RST = 2'h0;
   localparam logic [1:0] FULL_MENU = 2'h2;

   // ------------------------------------------------------------
   // menu, items and views
   // ------------------------------------------------------------
   localparam logic [2:0] MENU_FIRST = 3'h1;
   localparam logic [2:0] IO_MENU = 3'h4;
   localparam logic [2:0] ITEM_TERM = 3'h0;
   localparam logic [2:0] ITEM_COMM = 3'h1;
   localparam logic [2:0] ITEM_VOLT = 3'h2;
   localparam logic [2:0] ITEM_CURR = 3'h3;
   localparam logic [2:0] ITEM_METER = 3'h4;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_MENU = 2'b01,
      ST_LIST = 2'b10,
      ST_DATA = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      VW_SEG = 2'b00,
      VW_HEX_IN = 2'b01,
      VW_HEX_OUT = 2'b10
   } view_t;

   // ------------------------------------------------------------
   // status word bit positions and segment patterns (dp g f e d c b a)
   // ------------------------------------------------------------
   localparam int BIT_CMD_FORWARD = 13;
   localparam int BIT_CMD_REVERSE = 14;
   localparam int BIT_RST = 15;
   localparam int BIT_RELAY = 8;
   localparam logic [7:0] SEG_BLANK = 8'h00;
   localparam logic [7:0] SEG_DASH = 8'h40;
   localparam logic [7:0] SEG_UNDER = 8'h08;
   localparam logic [7:0] SEG_DP = 8'h80;

   // hex digit as lit on the monitor
   function automatic logic [7:0] hex_seg(input logic [3:0] v);
      case (v)
         4'h0: return 8'h3f;
         4'h1: return 8'h06;
         4'h2: return 8'h5b;
         4'h3: return 8'h4f;
         4'h4: return 8'h66;
         4'h5: return 8'h6d;
         4'h6: return 8'h7d;
         4'h7: return 8'h07;
         4'h8: return 8'h7f;
         4'h9: return 8'h6f;
         4'ha: return 8'h77;
         4'hb: return 8'h7c;
         4'hc: return 8'h39;
         4'hd: return 8'h5e;
         4'he: return 8'h79;
         default: return 8'h71;
      endcase
   endfunction

   // nibble k of a status word
   function automatic logic [3:0] nib(input logic [15:0] w, input logic [1:0] k);
      return w[{k, 2'b00} +: 4];
   endfunction

endpackage

// [common/io_link_if.sv]
// synchronised terminal levels and key press pulses
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface io_link_if;
   logic [4:0] term_in;  // forward, reverse, general one..three
   logic trans_on;       // transistor output circuit closed
   logic relay;          // relay normally-open side closed
   logic key_prg;        // one-cycle press pulses
   logic key_func;
   logic key_up;
   logic key_down;
   modport cond (output term_in, trans_on, relay, key_prg, key_func, key_up, key_down);
   modport core (input term_in, trans_on, relay, key_prg, key_func, key_up, key_down);
endinterface
`default_nettype wire

// [hdl/key_term_sync.sv]
// pin conditioning: two-flop synchronisers for terminals and keys,
// press pulses on the rising edge of each synchronised key
// assumes pins are asynchronous to sys_clk and keys are already debounced
`timescale 1ns/1ps
`default_nettype none
module key_term_sync
   import iochk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic forward_run_input,
   input wire logic reverse_run_input,
   input wire logic general_input_one,
   input wire logic general_input_two,
   input wire logic general_input_three,
   input wire logic transistor_output,
   input wire logic relay_contact_output,
   input wire logic key_program,
   input wire logic key_function,
   input wire logic key_up,
   input wire logic key_down,
   io_link_if.cond lk
);

   typedef struct packed {
      logic [10:0] s1;
      logic [10:0] s2;
      logic [3:0] kprev;
      logic [3:0] kpulse;
   } sync_st_t;

   sync_st_t s_reg;
   sync_st_t s_next;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // first stage feeds only the second stage
   always_comb begin
      s_next = s_reg;
      s_next.s1 = {key_down, key_up, key_function, key_program,
                   relay_contact_output, transistor_output, general_input_three,
                   general_input_two, general_input_one, reverse_run_input,
                   forward_run_input};
      s_next.s2 = s_reg.s1;
      s_next.kprev = s_reg.s2[10:7];
      s_next.kpulse = s_reg.s2[10:7] & ~s_reg.kprev;
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flops
   assign lk.term_in = s_reg.s2[4:0];
   assign lk.trans_on = s_reg.s2[5];
   assign lk.relay = s_reg.s2[6];
   assign lk.key_prg = s_reg.kpulse[0];
   assign lk.key_func = s_reg.kpulse[1];
   assign lk.key_up = s_reg.kpulse[2];
   assign lk.key_down = s_reg.kpulse[3];

endmodule
`default_nettype wire

// [hdl/io_check_display.sv]
// i/o checking display core: key-driven menu, item selection and
// four-digit seven-segment rendering, plus a small register port
// assumes comm commands and analog readings come from sys_clk logic,
// readings already scaled to four bcd digits with two decimals
`timescale 1ns/1ps
`default_nettype none
module io_check_display
   import iochk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic forward_run_input,
   input wire logic reverse_run_input,
   input wire logic general_input_one,
   input wire logic general_input_two,
   input wire logic general_input_three,
   input wire logic transistor_output,
   input wire logic relay_contact_output,
   input wire logic key_program,
   input wire logic key_function,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic [4:0] comm_terminal_inputs,
   input wire logic comm_forward_command,
   input wire logic comm_reverse_command,
   input wire logic comm_reset_command,
   input wire logic [15:0] voltage_reading,
   input wire logic [15:0] current_reading,
   input wire logic [15:0] meter_output_reading,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [31:0] digit_segments
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      mode_t mode;
      logic [2:0] menu;
      logic [2:0] item;
      view_t view;
      logic [1:0] scope;
      logic [31:0] digits;
      logic [31:0] rdata;
   } core_st_t;

   core_st_t s_reg;
   core_st_t s_next;

   io_link_if lk();

   logic [4:0] term_now;
   logic comm_on;
   logic [15:0] in_w;
   logic [15:0] phys_w;
   logic [15:0] out_w;
   logic [15:0] shown_w;
   logic no_input;
   logic term_item;

   // ------------------------------------------------------------
   // pin conditioning
   // ------------------------------------------------------------
   key_term_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .forward_run_input(forward_run_input),
      .reverse_run_input(reverse_run_input),
      .general_input_one(general_input_one),
      .general_input_two(general_input_two),
      .general_input_three(general_input_three),
      .transistor_output(transistor_output),
      .relay_contact_output(relay_contact_output),
      .key_program(key_program),
      .key_function(key_function),
      .key_up(key_up),
      .key_down(key_down),
      .lk(lk)
   );

   // ------------------------------------------------------------
   // status words
   // ------------------------------------------------------------
   // comm item takes received terminal states and adds three commands
   assign comm_on = (s_reg.item == ITEM_COMM);
   assign term_now = comm_on ? comm_terminal_inputs : lk.term_in;
   assign phys_w = {11'h000, lk.term_in};
   assign in_w = {comm_on & comm_reset_command, comm_on & comm_reverse_command,
                  comm_on & comm_forward_command, 8'h00, term_now};
   assign out_w = {7'h00, lk.relay, 7'h00, lk.trans_on};
   assign shown_w = (s_reg.view == VW_HEX_OUT) ? out_w : in_w;
   assign no_input = (term_now == 5'h00) &&
                     !(comm_on && (comm_forward_command || comm_reverse_command ||
                                   comm_reset_command));
   assign term_item = (s_reg.item == ITEM_TERM) || (s_reg.item == ITEM_COMM);

   // sixteen-bit word as four hex digits, leftmost holds the top nibble
   function automatic logic [31:0] hex4(input logic [15:0] w);
      return {hex_seg(nib(w, 2'd3)), hex_seg(nib(w, 2'd2)),
              hex_seg(nib(w, 2'd1)), hex_seg(nib(w, 2'd0))};
   endfunction

   // two-decimal reading: point after the second digit
   function automatic logic [31:0] reading4(input logic [15:0] w);
      return hex4(w) | {8'h00, SEG_DP, 16'h0000};
   endfunction

   // ------------------------------------------------------------
   // next state: register port, key walk, display
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.rdata = 32'h0000_0000;

      // only the scope field is writable; other offsets ignore writes
      if (reg_wr && (reg_addr == CTRL_OFS)) begin
         s_next.scope = reg_wdata[1:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            CTRL_OFS: s_next.rdata = {30'h0000_0000, s_reg.scope};
            STATUS_OFS: s_next.rdata = {22'h00_0000, s_reg.view, s_reg.item,
                                        s_reg.menu, s_reg.mode};
            TERMS_OFS: s_next.rdata = {out_w, phys_w};
            DIGITS_OFS: s_next.rdata = s_reg.digits;
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end

      // key walk; program key steps back one level, except in running mode where it opens the menu
      case (s_reg.mode)
         ST_RUN: begin
            if (lk.key_prg) begin
               s_next.mode = ST_MENU;
               s_next.menu = MENU_FIRST;
            end
         end
         ST_MENU: begin
            if (lk.key_prg) begin
               s_next.mode = ST_RUN;
            end else if (lk.key_up) begin
               s_next.menu = s_reg.menu + 3'h1;
            end else if (lk.key_down) begin
               s_next.menu = s_reg.menu - 3'h1;
            end else if (lk.key_func && (s_reg.menu == IO_MENU) &&
                         (s_reg.scope == FULL_MENU)) begin
               s_next.mode = ST_LIST;
               s_next.item = ITEM_TERM;
            end
         end
         ST_LIST: begin
            if (lk.key_prg) begin
               s_next.mode = ST_MENU;
            end else if (lk.key_up) begin
               s_next.item = (s_reg.item == ITEM_METER) ? ITEM_TERM : s_reg.item + 3'h1;
            end else if (lk.key_down) begin
               s_next.item = (s_reg.item == ITEM_TERM) ? ITEM_METER : s_reg.item - 3'h1;
            end else if (lk.key_func) begin
               s_next.mode = ST_DATA;
               s_next.view = VW_SEG;
            end
         end
         ST_DATA: begin
            if (lk.key_prg) begin
               s_next.mode = ST_LIST;
            end else if (term_item && lk.key_up) begin
               case (s_reg.view)
                  VW_SEG: s_next.view = VW_HEX_IN;
                  VW_HEX_IN: s_next.view = VW_HEX_OUT;
                  default: s_next.view = VW_SEG;
               endcase
            end else if (term_item && lk.key_down) begin
               case (s_reg.view)
                  VW_SEG: s_next.view = VW_HEX_OUT;
                  VW_HEX_OUT: s_next.view = VW_HEX_IN;
                  default: s_next.view = VW_SEG;
               endcase
            end
         end
         default: s_next.mode = ST_RUN;
      endcase

      // display composition from the current state
      case (s_reg.mode)
         ST_MENU: s_next.digits = {SEG_BLANK, SEG_BLANK, hex_seg({1'b0, s_reg.menu}),
                                   SEG_BLANK};
         ST_LIST: s_next.digits = {hex_seg(4'h4), SEG_UNDER, hex_seg(4'h0),
                                   hex_seg({1'b0, s_reg.item})};
         ST_DATA: begin
            case (s_reg.item)
               ITEM_VOLT: s_next.digits = reading4(voltage_reading);
               ITEM_CURR: s_next.digits = reading4(current_reading);
               ITEM_METER: s_next.digits = reading4(meter_output_reading);
               default: begin
                  if (s_reg.view == VW_SEG) begin
                     s_next.digits[7:0] = {3'b000, term_now};
                     s_next.digits[15:8] = {in_w[BIT_RST], in_w[BIT_CMD_REVERSE],
                                            in_w[BIT_CMD_FORWARD], 5'b00000};
                     s_next.digits[23:16] = {7'h00, lk.trans_on};
                     s_next.digits[31:24] = {7'h00, lk.relay};
                     if (no_input) begin
                        s_next.digits = s_next.digits |
                                        {SEG_DASH, SEG_DASH, SEG_DASH, SEG_DASH};
                     end
                  end else begin
                     s_next.digits = hex4(shown_w);
                  end
               end
            endcase
         end
         default: s_next.digits = {SEG_BLANK, SEG_BLANK, SEG_BLANK, SEG_BLANK};
      endcase
   end

   // state register; reset lands in running mode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '{mode: ST_RUN, menu: MENU_FIRST, item: ITEM_TERM, view: VW_SEG,
                    scope: SCOPE_RST, digits: 32'h0000_0000,
                    rdata: 32'h0000_0000};
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign digit_segments = s_reg.digits;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_term_seg;
      (s_reg.mode == ST_DATA) && (s_reg.item == ITEM_TERM) && (s_reg.view == VW_SEG);
   endsequence

   sequence s_hex_shown;
      (s_reg.mode == ST_DATA) && term_item && (s_reg.view != VW_SEG);
   endsequence

   sequence s_run_idle;
      (s_reg.mode == ST_RUN) && !lk.key_prg;
   endsequence

   sequence s_open_io;
      (s_reg.mode == ST_MENU) && !lk.key_prg && !lk.key_up && !lk.key_down &&
      lk.key_func && (s_reg.menu == IO_MENU);
   endsequence

   a_hex_low_digit: assert property (
      s_hex_shown |=> digit_segments[7:0] == hex_seg(nib($past(shown_w), 2'd0)))
      else $error("low hex digit wrong");

   a_seg_inputs: assert property (
      s_term_seg |=> digit_segments[4:0] == $past(lk.term_in))
      else $error("input segments wrong");

   a_seg_transistor: assert property (
      s_term_seg |=> digit_segments[16] == $past(lk.trans_on))
      else $error("transistor segment wrong");

   a_seg_relay: assert property (
      s_term_seg |=> digit_segments[24] == $past(lk.relay))
      else $error("relay segment wrong");

   a_dash_row: assert property (
      s_term_seg ##0 (lk.term_in == 5'h00) |=>
         digit_segments[6] && digit_segments[14] && digit_segments[22] &&
         digit_segments[30])
      else $error("dash row missing");

   // the dash row shares segment g of digit 2 with the reverse command
   a_comm_cmd_segs: assert property (
      (s_reg.mode == ST_DATA) && comm_on && (s_reg.view == VW_SEG) |=>
         digit_segments[15:13] == {$past(comm_reset_command),
                                   $past(comm_reverse_command) | $past(no_input),
                                   $past(comm_forward_command)})
      else $error("comm command segments wrong");

   a_term_source: assert property (
      s_term_seg ##0 (lk.term_in != comm_terminal_inputs) |=>
         digit_segments[4:0] != $past(comm_terminal_inputs))
      else $error("first item not from terminals");

   a_volt_item: assert property (
      (s_reg.mode == ST_DATA) && (s_reg.item == ITEM_VOLT) |=>
         digit_segments[23:16] == (hex_seg(nib($past(voltage_reading), 2'd2)) | SEG_DP))
      else $error("voltage reading wrong");

   a_curr_item: assert property (
      (s_reg.mode == ST_DATA) && (s_reg.item == ITEM_CURR) |=>
         digit_segments[31:24] == hex_seg(nib($past(current_reading), 2'd3)))
      else $error("current reading wrong");

   a_meter_item: assert property (
      (s_reg.mode == ST_DATA) && (s_reg.item == ITEM_METER) |=>
         digit_segments[7:0] == hex_seg(nib($past(meter_output_reading), 2'd0)))
      else $error("meter reading wrong");

   a_menu_gate: assert property (
      s_open_io |=> (s_reg.mode == ST_LIST) == ($past(s_reg.scope) == FULL_MENU))
      else $error("menu scope gate wrong");

   a_view_toggle: assert property (
      (s_reg.mode == ST_DATA) && term_item && !lk.key_prg && lk.key_up |=>
         s_reg.view != $past(s_reg.view))
      else $error("view did not toggle");

   a_run_hold: assert property (
      s_run_idle |=> s_reg.mode == ST_RUN)
      else $error("left running mode without key");

   a_hex_in_bits: assert property (
      s_hex_shown ##0 (s_reg.view == VW_HEX_IN) && (s_reg.item == ITEM_TERM) |=>
         digit_segments[15:8] == hex_seg({3'b000, $past(lk.term_in[4])}))
      else $error("input bit placement wrong");

   a_hex_out_bits: assert property (
      s_hex_shown ##0 (s_reg.view == VW_HEX_OUT) |=>
         digit_segments[23:16] == hex_seg({3'b000, $past(lk.relay)}))
      else $error("relay bit placement wrong");

   a_hex_top_digit: assert property (
      s_hex_shown |=> digit_segments[31:24] == hex_seg(nib($past(shown_w), 2'd3)))
      else $error("top hex digit wrong");

   a_hex_second_digit: assert property (
      s_hex_shown |=> digit_segments[15:8] == hex_seg(nib($past(shown_w), 2'd1)))
      else $error("second hex digit wrong");

   a_comm_source: assert property (
      (s_reg.mode == ST_DATA) && comm_on && (s_reg.view == VW_SEG) |=>
         digit_segments[4:0] == $past(comm_terminal_inputs))
      else $error("comm terminal segments wrong");

   a_view_down: assert property (
      (s_reg.mode == ST_DATA) && term_item && !lk.key_prg && !lk.key_up && lk.key_down |=>
         s_reg.view != $past(s_reg.view))
      else $error("view did not step back");

   // running mode keeps the monitor dark until the program key
   a_run_blank: assert property (
      (s_reg.mode == ST_RUN) |=> digit_segments == 32'h0000_0000)
      else $error("running display not blank");

endmodule
`default_nettype wire

// [verif/keypad_model.sv]
// operator keypad model: presses one key at a time, already debounced
// assumes sys_clk of the bench; released keys read low
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
   input wire logic sys_clk,
   output logic key_program,
   output logic key_function,
   output logic key_up,
   output logic key_down
);
   logic [3:0] key_reg = 4'h0;
   // order: program, function, up, down
   assign {key_down, key_up, key_function, key_program} = key_reg;
   // hold long enough to pass the synchronisers, one press per call
   task automatic press(input int idx);
      @(posedge sys_clk);
      key_reg[idx] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      key_reg[idx] <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the i/o checking display core
// assumes the keypad model drives the keys, the bench drives all else
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top
   import iochk_pkg::*;
;
   logic sys_clk, rst, fw, rv, g1, g2, g3, tr, rly, kp, kf, ku, kd, cf, cr, cx, wr, rd;
   logic [4:0] cti;
   logic [15:0] vr, crd, mr, w;
   logic [3:0] ra;
   logic [31:0] wd, rdat, segs, got, e;
   int errors = 0, checks = 0, cyc = 0;
   logic [7:0] hx [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
      8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
   typedef struct packed {logic [4:0] t; logic y; logic r; logic [31:0] e;} row_t;
   // ---------------------------------------------
   // segment view rows: pins beside expected digits
   // ---------------------------------------------
   row_t rows [7] = '{'{5'h00, 1'b0, 1'b0, 32'h4040_4040}, '{5'h01, 1'b0, 1'b0, 32'h0000_0001},
      '{5'h1f, 1'b1, 1'b1, 32'h0101_001f}, '{5'h02, 1'b0, 1'b1, 32'h0100_0002},
      '{5'h00, 1'b1, 1'b0, 32'h4041_4040}, '{5'h10, 1'b0, 1'b0, 32'h0000_0010},
      '{5'h05, 1'b1, 1'b0, 32'h0001_0005}};

   io_check_display u_io_check_display (.sys_clk(sys_clk), .rst(rst),
      .forward_run_input(fw), .reverse_run_input(rv), .general_input_one(g1),
      .general_input_two(g2), .general_input_three(g3), .transistor_output(tr),
      .relay_contact_output(rly), .key_program(kp), .key_function(kf), .key_up(ku),
      .key_down(kd), .comm_terminal_inputs(cti), .comm_forward_command(cf),
      .comm_reverse_command(cr), .comm_reset_command(cx), .voltage_reading(vr),
      .current_reading(crd), .meter_output_reading(mr), .reg_addr(ra), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .digit_segments(segs));
   keypad_model u_keypad_model (.sys_clk(sys_clk), .key_program(kp), .key_function(kf),
      .key_up(ku), .key_down(kd));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // hang guard, far above the roughly 500 cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end

   function automatic logic [31:0] hexw(input logic [15:0] v);
      return {hx[v[15:12]], hx[v[11:8]], hx[v[7:4]], hx[v[3:0]]};
   endfunction
   // pins pass two sync flops, so allow a margin before sampling
   task automatic pins(input logic [4:0] t, input logic y, input logic r);
      @(posedge sys_clk);
      {g3, g2, g1, rv, fw} <= t;
      tr <= y;
      rly <= r;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge sys_clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 got = rdat;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic key(input int i);
      u_keypad_model.press(i);
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      rst = 1'b1;
      {fw, rv, g1, g2, g3, tr, rly, cf, cr, cx, wr, rd} = '0;
      {cti, vr, crd, mr, ra, wd} = '0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK("blank", 32'h0, segs)
      rreg(STATUS_OFS);
      `CHK("mode", ST_RUN, got[1:0])
      // menu 4 must refuse entry until scope is full menu
      key(0);
      repeat (3) key(2);
      key(1);
      rreg(STATUS_OFS);
      `CHK("refuse", {IO_MENU, ST_MENU}, got[4:0])
      wreg(CTRL_OFS, 32'h0000_0002);
      rreg(CTRL_OFS);
      `CHK("ctrl", 32'h0000_0002, got)
      rreg(4'h2);
      `CHK("hole", 32'h0, got)
      key(1);
      key(1);
      $display("test menu done");
      foreach (rows[i]) begin
         pins(rows[i].t, rows[i].y, rows[i].r);
         `CHK("seg", rows[i].e, segs)
      end
      for (int v = 0; v < 2; v++) begin
         key(2);
         foreach (rows[i]) if (rows[i].t != 5'h00) begin
            pins(rows[i].t, rows[i].y, rows[i].r);
            w = v ? {7'h00, rows[i].r, 7'h00, rows[i].y} : {11'h000, rows[i].t};
            `CHK("hex", hexw(w), segs)
         end
      end
      key(2);
      `CHK("wrap", rows[6].e, segs)
      key(3);
      `CHK("down", hexw(16'h0001), segs)
      key(3);
      `CHK("down2", hexw(16'h0005), segs)
      $display("test terminals done");
      key(0);
      key(2);
      key(1);
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         {cx, cr, cf} <= 3'b001 << i;
         cti <= 5'h03;
         repeat (3) @(posedge sys_clk);
         #1;
         `CHK("comm", {8'h00, 8'h01, 8'h20 << i, 8'h03}, segs)
      end
      key(2);
      `CHK("commhex", hexw(16'h8003), segs)
      $display("test comm done");
      @(posedge sys_clk);
      vr <= 16'h1234;
      crd <= 16'h5678;
      mr <= 16'h0905;
      for (int i = 2; i < 5; i++) begin
         key(0);
         key(2);
         key(1);
         w = (i == 2) ? 16'h1234 : (i == 3) ? 16'h5678 : 16'h0905;
         e = hexw(w) | 32'h0080_0000;
         `CHK("analog", e, segs)
         key(2);
         `CHK("hold", e, segs)
      end
      rreg(DIGITS_OFS);
      `CHK("digreg", e, got)
      rreg(TERMS_OFS);
      `CHK("terms", 32'h0001_0005, got)
      $display("test analog done");
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("rerst", 32'h0, segs)
      $display("test reset done");
      stop_test();
   end
endmodule
`default_nettype wire
